// ---- design/fieldbus_coupler_status_leds.sv ----
`timescale 1ns/1ns
module fieldbus_coupler_status_leds
  import led_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
)
(
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_selftest_done,
  input wire logic i_selftest_pass,
  input wire logic i_hw_defect,
  input wire logic i_boot_active,
  input wire logic i_sys_error,
  input wire logic i_cfg_received,
  input wire logic i_mode_set,
  input wire logic i_param_error,
  input wire logic i_cfg_error,
  input wire logic i_comm_ready,
  input wire logic i_comm_active,
  input wire logic i_bus_error,
  input wire logic i_master_mode,
  input wire logic i_io_exchange,
  input wire logic i_token_held,
  output logic o_led_ready,
  output logic o_led_run,
  output logic o_led_status,
  output logic o_led_error,
  output logic o_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // flash sources
  logic tick;
  logic cyc_flash;
  logic nc_flash;

  flash_gen #(
    .TICK_CYCLES_P(TICK_CYCLES_P)
  ) u_flash (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .o_tick(tick),
    .o_cyclic(cyc_flash),
    .o_noncyclic(nc_flash)
  );

  ////////////////////////////////////////////////////////////////////////////
  // ready state machine
  ready_state_t state;
  ready_state_t next_state;

  always_comb
  begin
    next_state = state;
    case (state)
      RS_SELFTEST:
      begin
        if (i_hw_defect)
          next_state = RS_DEFECT;
        else if (i_selftest_done && !i_selftest_pass)
          next_state = RS_FAILED;
        else if (i_selftest_done)
          next_state = i_boot_active ? RS_BOOT : RS_READY;
      end
      RS_READY:
      begin
        if (i_hw_defect)
          next_state = RS_DEFECT;
        else if (i_sys_error)
          next_state = RS_FAILED;
        else if (i_boot_active)
          next_state = RS_BOOT;
      end
      RS_BOOT:
      begin
        if (i_hw_defect)
          next_state = RS_DEFECT;
        else if (!i_boot_active)
          next_state = RS_READY;
      end
      RS_FAILED:
      begin
        // initialization stays halted until reset
        if (i_hw_defect)
          next_state = RS_DEFECT;
      end
      RS_DEFECT:
      begin
        next_state = RS_DEFECT;
      end
      default:
      begin
        next_state = RS_SELFTEST;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      state <= RS_SELFTEST;
    else
      state <= next_state;
  end

  ////////////////////////////////////////////////////////////////////////////
  // indicator selection
  logic [1:0] ctrl;
  logic [CNT_W-1:0] settle_cnt;
  logic mode_q;
  wire led_en = ctrl[CTRL_EN_BIT];
  wire settle_active = settle_cnt != '0;
  wire init_ok = state == RS_READY;
  wire configured = init_ok && i_cfg_received && i_mode_set;
  wire cfg_fault = init_ok && (i_param_error || i_cfg_error);
  wire ready_raw = (state == RS_READY) ? 1'b1 :
                   (state == RS_BOOT) ? cyc_flash :
                   (state == RS_FAILED) ? nc_flash : 1'b0;
  wire run_raw = !init_ok ? 1'b0 :
                 cfg_fault ? nc_flash :
                 !configured ? 1'b0 :
                 i_comm_active ? 1'b1 :
                 i_comm_ready ? cyc_flash : 1'b0;
  wire status_raw = configured && (i_master_mode ? i_token_held : i_io_exchange);
  wire error_raw = i_bus_error;
  wire ready_entry = next_state == RS_READY && state != RS_READY;
  wire mode_chg = init_ok && (mode_q != i_master_mode);
  wire settle_trig = ctrl[CTRL_SETTLE_BIT] && (ready_entry || mode_chg);

  // brief all-on lamp window while the coupler settles
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      settle_cnt <= '0;
      mode_q <= 1'b0;
    end
    else
    begin
      mode_q <= i_master_mode;
      if (settle_trig)
        settle_cnt <= CNT_W'(SETTLE_TICKS);
      else if (tick && settle_active)
        settle_cnt <= settle_cnt - 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_led_ready <= 1'b0;
      o_led_run <= 1'b0;
      o_led_status <= 1'b0;
      o_led_error <= 1'b0;
    end
    else
    begin
      o_led_ready <= led_en && (settle_active || ready_raw);
      o_led_run <= led_en && (settle_active || run_raw);
      o_led_status <= led_en && (settle_active || status_raw);
      o_led_error <= led_en && (settle_active || error_raw);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // events and interrupt
  logic cfg_fault_q;
  logic bus_err_q;
  logic comm_q;
  logic [EV_W-1:0] irq_status;
  logic [EV_W-1:0] irq_mask;
  logic [EV_W-1:0] ev;

  always_comb
  begin
    ev = '0;
    ev[EV_FAIL] = next_state == RS_FAILED && state != RS_FAILED;
    ev[EV_CFGERR] = cfg_fault && !cfg_fault_q;
    ev[EV_BUSERR] = i_bus_error && !bus_err_q;
    ev[EV_COMM] = i_comm_active && !comm_q;
    ev[EV_MODE] = mode_chg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave
  wire req = i_wb_cyc && i_wb_stb && !o_wb_ack;
  // a write lands on the edge at which the master samples ack
  wire wr = i_wb_cyc && i_wb_stb && o_wb_ack && i_wb_we && i_wb_sel[0];
  wire hit_ctrl = i_wb_adr == ADDR_CTRL;
  wire hit_state = i_wb_adr == ADDR_STATE;
  wire hit_stat = i_wb_adr == ADDR_IRQ_STATUS;
  wire hit_mask = i_wb_adr == ADDR_IRQ_MASK;
  wire [EV_W-1:0] irq_clr = (wr && hit_stat) ? i_wb_dat[EV_W-1:0] : '0;
  wire [31:0] state_word = {21'h000000, i_master_mode, configured, state,
                            o_led_error, o_led_status, o_led_run, o_led_ready};
  wire [31:0] rd_mux = hit_ctrl ? {30'h00000000, ctrl} :
                       hit_state ? state_word :
                       hit_stat ? {27'h0000000, irq_status} :
                       hit_mask ? {27'h0000000, irq_mask} : 32'h00000000;

  assign o_irq = |(irq_status & irq_mask);

  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      cfg_fault_q <= 1'b0;
      bus_err_q <= 1'b0;
      comm_q <= 1'b0;
      irq_status <= '0;
    end
    else
    begin
      cfg_fault_q <= cfg_fault;
      bus_err_q <= i_bus_error;
      comm_q <= i_comm_active;
      // a new event wins over a simultaneous clear
      irq_status <= (irq_status & ~irq_clr) | ev;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      ctrl <= CTRL_RESET;
      irq_mask <= IRQ_MASK_RESET;
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h00000000;
    end
    else
    begin
      o_wb_ack <= req;
      if (req)
        o_wb_dat <= rd_mux;
      if (wr && hit_ctrl)
        ctrl <= i_wb_dat[1:0];
      if (wr && hit_mask)
        irq_mask <= i_wb_dat[EV_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_reset_n);

  sequence s_settle_start;
    settle_trig && led_en;
  endsequence

  sequence s_all_lit;
    (o_led_ready && o_led_run && o_led_status && o_led_error) [*3];
  endsequence

  wire quiet = led_en && !settle_active;

  ready_steady_a: assert property (quiet && state == RS_READY |=> o_led_ready)
    else $error("ready led not steady after pass");
  fail_halt_a: assert property (state == RS_FAILED |=>
    (state == RS_FAILED || state == RS_DEFECT) && !configured)
    else $error("initialization resumed after failed self-test");
  boot_blink_a: assert property (quiet && state == RS_BOOT |=>
    o_led_ready == $past(cyc_flash))
    else $error("ready led not blinking in boot loader");
  defect_dark_a: assert property (quiet && state == RS_DEFECT |=> !o_led_ready)
    else $error("ready led lit on defect");
  run_init_a: assert property (!settle_active && !init_ok |=> !o_led_run)
    else $error("run led lit during initialization");
  cfg_fault_a: assert property (quiet && cfg_fault |=> o_led_run == $past(nc_flash))
    else $error("run led not flashing on config fault");
  run_wait_a: assert property (quiet && configured && !cfg_fault && !i_comm_active &&
    i_comm_ready |=> o_led_run == $past(cyc_flash))
    else $error("run led not blinking while waiting");
  run_active_a: assert property (quiet && configured && !cfg_fault && i_comm_active
    |=> o_led_run)
    else $error("run led off with communication active");
  error_led_a: assert property (quiet |=> o_led_error == $past(i_bus_error))
    else $error("error led does not follow bus error");
  slave_status_a: assert property (quiet && configured && !i_master_mode |=>
    o_led_status == $past(i_io_exchange))
    else $error("slave status led wrong");
  master_status_a: assert property (quiet && configured && i_master_mode |=>
    o_led_status == $past(i_token_held))
    else $error("master status led wrong");
  settle_lamp_a: assert property (s_settle_start |=> ##1 s_all_lit)
    else $error("settle lamp window missing");
  irq_set_wins_a: assert property (ev != '0 |=> (irq_status & $past(ev)) == $past(ev))
    else $error("event lost against clear");

endmodule : fieldbus_coupler_status_leds

// ---- design/flash_gen.sv ----
`timescale 1ns/1ns
module flash_gen
  import led_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
)
(
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  output logic o_tick,
  output logic o_cyclic,
  output logic o_noncyclic
);

  logic [TICK_W-1:0] pre;
  logic [CNT_W-1:0] cyc_cnt;
  logic [CNT_W-1:0] step_cnt;
  logic [3:0] pat_idx;
  wire tick = pre == TICK_W'(TICK_CYCLES_P - 1);
  wire cyc_wrap = tick && cnt_hit(cyc_cnt, CYC_HALF_TICKS);
  wire step_wrap = tick && cnt_hit(step_cnt, NONCYC_STEP_TICKS);

  assign o_tick = tick;

  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      pre <= '0;
    end
    else
    begin
      pre <= tick ? '0 : pre + 1'b1;
    end
  end

  // fixed half period gives a regular blink
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      cyc_cnt <= '0;
      o_cyclic <= 1'b0;
    end
    else if (tick)
    begin
      cyc_cnt <= cyc_wrap ? '0 : cyc_cnt + 1'b1;
      o_cyclic <= cyc_wrap ? ~o_cyclic : o_cyclic;
    end
  end

  // irregular pattern, distinct from the regular blink
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      step_cnt <= '0;
      pat_idx <= '0;
      o_noncyclic <= 1'b0;
    end
    else if (tick)
    begin
      step_cnt <= step_wrap ? '0 : step_cnt + 1'b1;
      pat_idx <= step_wrap ? pat_idx + 1'b1 : pat_idx;
      o_noncyclic <= NONCYC_PATTERN[pat_idx];
    end
  end

  cyc_regular_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    $changed(o_cyclic) |-> $past(cyc_wrap))
    else $error("cyclic blink changed off its period");

endmodule : flash_gen

// ---- design/led_pkg.sv ----
package led_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_HZ = 100_000_000;
  localparam int TICK_MS = 10;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int TICK_W = 20;
  localparam int CNT_W = 5;
  localparam int CYC_HALF_TICKS = 25;
  localparam int NONCYC_STEP_TICKS = 10;
  localparam int SETTLE_TICKS = 20;
  localparam logic [15:0] NONCYC_PATTERN = 16'hE4A8;

  ////////////////////////////////////////////////////////////////////////////
  // register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATE = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_SETTLE_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h3;
  localparam int EV_W = 5;
  localparam int EV_FAIL = 0;
  localparam int EV_CFGERR = 1;
  localparam int EV_BUSERR = 2;
  localparam int EV_COMM = 3;
  localparam int EV_MODE = 4;
  localparam logic [EV_W-1:0] IRQ_MASK_RESET = 5'h00;
  localparam int ST_LED_LSB = 0;
  localparam int ST_STATE_LSB = 4;
  localparam int ST_CFG_BIT = 9;
  localparam int ST_MASTER_BIT = 10;

  ////////////////////////////////////////////////////////////////////////////
  // ready state machine
  typedef enum logic [4:0] {
    RS_SELFTEST = 5'h01,
    RS_READY = 5'h02,
    RS_BOOT = 5'h04,
    RS_FAILED = 5'h08,
    RS_DEFECT = 5'h10
  } ready_state_t;

  function automatic logic cnt_hit(input logic [CNT_W-1:0] c, input int lim);
    return c == CNT_W'(lim - 1);
  endfunction : cnt_hit

endpackage : led_pkg

// ---- dv/fieldbus_coupler_status_leds_bench.sv ----
`timescale 1ns/1ns
module fieldbus_coupler_status_leds_bench;
  import led_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, clr = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, q, rdat;
  logic [3:0] sel = 4'h0;
  logic ack, l_rdy, l_run, l_sta, l_err, irq;
  logic st_done = 1'b0, st_pass = 1'b0, defect = 1'b0, boot = 1'b0;
  logic sys_err = 1'b0, cfg_rx = 1'b0, mode_set = 1'b0, par_err = 1'b0;
  logic cfg_err = 1'b0, comm_rdy = 1'b0, comm_act = 1'b0;
  logic bus_err = 1'b0, master = 1'b0, io_x = 1'b0, token = 1'b0;
  logic [15:0] rf, nf;
  int err_count = 0, checked = 0, cycles = 0;
  always #5 clk = ~clk;
  fieldbus_coupler_status_leds #(.TICK_CYCLES_P(4)) uut (.i_ref_clk(clk), .i_reset_n(rst_n),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat),
    .i_wb_sel(sel), .o_wb_dat(rdat), .o_wb_ack(ack), .i_selftest_done(st_done),
    .i_selftest_pass(st_pass), .i_hw_defect(defect), .i_boot_active(boot),
    .i_sys_error(sys_err), .i_cfg_received(cfg_rx), .i_mode_set(mode_set),
    .i_param_error(par_err), .i_cfg_error(cfg_err), .i_comm_ready(comm_rdy),
    .i_comm_active(comm_act), .i_bus_error(bus_err), .i_master_mode(master),
    .i_io_exchange(io_x), .i_token_held(token), .o_led_ready(l_rdy), .o_led_run(l_run),
    .o_led_status(l_sta), .o_led_error(l_err), .o_irq(irq));
  led_panel panel (.i_ref_clk(clk), .i_clear(clr), .i_led_ready(l_rdy), .i_led_run(l_run),
    .o_ready_flips(rf), .o_run_flips(nf));
  //////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // one classic cycle; waits for ack with a bounded count
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    @(posedge clk);
    while (ack !== 1'b1 && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 50)
      err_count++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb
  task automatic lamps(input logic [3:0] exp);
    check({28'h0, l_err, l_sta, l_run, l_rdy}, {28'h0, exp});
  endtask : lamps
  // counts lamp changes over n cycles and checks ready and run against bounds
  task automatic flips(input int n, input int rlo, input int rhi, input int nlo, input int nhi);
    clr <= 1'b1;
    tick(1);
    clr <= 1'b0;
    tick(n);
    check(32'(rf >= rlo && rf <= rhi), 32'h1);
    check(32'(nf >= nlo && nf <= nhi), 32'h1);
  endtask : flips
  task automatic reset_pass(input logic pass);
    rst_n <= 1'b0;
    tick(2);
    rst_n <= 1'b1;
    tick(3);
    st_done <= 1'b1;
    st_pass <= pass;
    tick(1);
    st_done <= 1'b0;
  endtask : reset_pass
  //////////////////////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      err_count++;
      give_verdict();
    end
  end
  initial
  begin
    tick(2);
    rst_n <= 1'b1;
    tick(1);
    lamps(4'h0);
    wb(1'b0, ADDR_CTRL, 32'h0);
    check(q, 32'h3);
    wb(1'b0, ADDR_IRQ_MASK, 32'h0);
    check(q, 32'h0);
    wb(1'b0, 8'h10, 32'h0);
    check(q, 32'h0);
    tick(20);
    lamps(4'h0);
    st_done <= 1'b1;
    st_pass <= 1'b1;
    tick(1);
    st_done <= 1'b0;
    tick(10);
    lamps(4'hF);
    tick(100);
    lamps(4'h1);
    wb(1'b1, ADDR_CTRL, 32'h1);
    wb(1'b0, ADDR_STATE, 32'h0);
    check({27'h0, q[8:4]}, 32'h2);
    comm_act <= 1'b1;
    cfg_rx <= 1'b1;
    tick(10);
    lamps(4'h1);
    mode_set <= 1'b1;
    tick(10);
    lamps(4'h3);
    comm_act <= 1'b0;
    comm_rdy <= 1'b1;
    flips(400, 0, 0, 3, 5);
    comm_rdy <= 1'b0;
    tick(5);
    lamps(4'h1);
    par_err <= 1'b1;
    flips(640, 0, 0, 9, 11);
    par_err <= 1'b0;
    cfg_err <= 1'b1;
    flips(640, 0, 0, 9, 11);
    cfg_err <= 1'b0;
    io_x <= 1'b1;
    tick(5);
    lamps(4'h5);
    io_x <= 1'b0;
    token <= 1'b1;
    tick(5);
    lamps(4'h1);
    master <= 1'b1;
    tick(5);
    lamps(4'h5);
    token <= 1'b0;
    io_x <= 1'b1;
    tick(5);
    lamps(4'h1);
    wb(1'b1, ADDR_IRQ_MASK, 32'h4);
    bus_err <= 1'b1;
    tick(5);
    lamps(4'h9);
    check(32'(irq), 32'h1);
    bus_err <= 1'b0;
    wb(1'b0, ADDR_IRQ_STATUS, 32'h0);
    check(q & 32'h4, 32'h4);
    lamps(4'h1);
    wb(1'b1, ADDR_IRQ_STATUS, 32'h4);
    check(32'(irq), 32'h0);
    wb(1'b1, ADDR_IRQ_MASK, 32'h0);
    bus_err <= 1'b1;
    tick(5);
    check(32'(irq), 32'h0);
    bus_err <= 1'b0;
    wb(1'b1, ADDR_CTRL, 32'h0);
    tick(3);
    lamps(4'h0);
    reset_pass(1'b0);
    flips(640, 9, 11, 0, 0);
    check(32'(l_run), 32'h0);
    defect <= 1'b1;
    reset_pass(1'b0);
    flips(640, 0, 0, 0, 0);
    lamps(4'h0);
    defect <= 1'b0;
    boot <= 1'b1;
    reset_pass(1'b1);
    tick(150);
    flips(400, 3, 5, 0, 0);
    boot <= 1'b0;
    tick(120);
    lamps(4'h1);
    sys_err <= 1'b1;
    flips(640, 9, 11, 0, 0);
    wb(1'b0, ADDR_IRQ_STATUS, 32'h0);
    check(q & 32'h1, 32'h1);
    give_verdict();
  end
endmodule : fieldbus_coupler_status_leds_bench

// ---- dv/led_panel.sv ----
`timescale 1ns/1ns
// operator's view of the panel: counts lamp changes to tell steady from flashing
module led_panel
(
  input wire logic i_ref_clk,
  input wire logic i_clear,
  input wire logic i_led_ready,
  input wire logic i_led_run,
  output logic [15:0] o_ready_flips,
  output logic [15:0] o_run_flips
);
  logic last_ready;
  logic last_run;
  always_ff @(posedge i_ref_clk)
  begin
    last_ready <= i_led_ready;
    last_run <= i_led_run;
    if (i_clear)
    begin
      o_ready_flips <= 16'h0000;
      o_run_flips <= 16'h0000;
    end
    else
    begin
      o_ready_flips <= o_ready_flips + 16'(i_led_ready != last_ready);
      o_run_flips <= o_run_flips + 16'(i_led_run != last_run);
    end
  end
endmodule : led_panel
